//--- logic/pslpr_params.svh
`ifndef PSLPR_PARAMS_SVH
`define PSLPR_PARAMS_SVH
// ----------------------------------------
// register offsets and page codes
// ----------------------------------------
`define PSLPR_REG_FIBER 5'h10
`define PSLPR_REG_INT_CAUSE 5'h1a
`define PSLPR_REG_AUX 5'h1c
`define PSLPR_REG_LED_MODE 5'h1d
`define PSLPR_REG_LED_BEH 5'h1e
`define PSLPR_REG_PAGE 5'h1f
`define PSLPR_PAGE_MAIN 16'h0000
`define PSLPR_PAGE_EXT1 16'h0001
`define PSLPR_PAGE_EXT4 16'h0004
`define PSLPR_PAGE_GPIO 16'h0010
// ----------------------------------------
// reset values and writable masks
// ----------------------------------------
`define PSLPR_LED_MODE_RST 16'h8021
`define PSLPR_LED_BEH_RST 16'h0400
`define PSLPR_LED_BEH_MASK 16'hddef
`define PSLPR_AUX_RST 16'h0004
`define PSLPR_AUX_MASK 16'h00c4
`define PSLPR_FIBER_RST 16'h0300
`define PSLPR_FIBER_MASK 16'hc300
`define PSLPR_FIBER_STICKY 16'h0300
`define PSLPR_CAUSE_VALID 15'h7fbf
// ----------------------------------------
// field positions
// ----------------------------------------
`define PSLPR_CAUSE_SPEED 14
`define PSLPR_CAUSE_FDX 12
`define PSLPR_CAUSE_RSVD 6
`define PSLPR_CAUSE_DOWNSHIFT 2
`define PSLPR_CAUSE_RXER 0
`define PSLPR_BEH_CU_ONLY 15
`define PSLPR_BEH_TXRX 14
`define PSLPR_BEH_PULSE 12
`define PSLPR_BEH_RATE_HI 11
`define PSLPR_BEH_RATE_LO 10
`define PSLPR_BEH_STRETCH_LO 5
// ----------------------------------------
// timing
// ----------------------------------------
`define PSLPR_CLK_HZ 10000000
`define PSLPR_LED_TICK_US 25000
`define PSLPR_PULSE_HZ 5000
`define PSLPR_SMI_PREAMBLE 6'd32
`define PSLPR_SMI_OP_READ 2'b10
`define PSLPR_SMI_OP_WRITE 2'b01
`endif

//--- logic/pslpr_pkg.sv
package pslpr_pkg;
   typedef enum logic [1:0] {
      SMI_IDLE = 2'b00,
      SMI_HDR = 2'b01,
      SMI_TA = 2'b10,
      SMI_DATA = 2'b11
   } pslpr_smi_state_type;
endpackage

//--- logic/pslpr_smi.sv
`timescale 1ns/1ps
`default_nettype none
`include "pslpr_params.svh"
module pslpr_smi
   import pslpr_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic mdc,
   input wire logic mdio_in,
   input wire logic [4:0] phy_addr,
   input wire logic [15:0] rd_data,
   output logic mdio_out,
   output logic mdio_oe,
   output logic wr_stb,
   output logic rd_stb,
   output logic [4:0] reg_addr,
   output logic [15:0] wr_data
);
   pslpr_smi_state_type state;
   logic mdc_q;
   logic rise;
   logic fall;
   logic is_read;
   logic [5:0] cnt;
   logic [15:0] sh;
   logic [15:0] out_sh;
   logic [12:0] hdr;

   assign rise = mdc & ~mdc_q;
   assign fall = ~mdc & mdc_q;
   assign hdr = {sh[11:0], mdio_in};

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         mdc_q <= 1'b0;
      else
         mdc_q <= mdc;
   end

   // ----------------------------------------
   // frame decode on mdc rising edges
   // ----------------------------------------
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state <= SMI_IDLE;
         cnt <= 6'h00;
         sh <= 16'h0000;
         is_read <= 1'b0;
         reg_addr <= 5'h00;
         wr_data <= 16'h0000;
         wr_stb <= 1'b0;
         rd_stb <= 1'b0;
      end
      else
      begin
         wr_stb <= 1'b0;
         rd_stb <= 1'b0;
         if (rise)
         begin
            unique case (state)
               SMI_IDLE:
               begin
                  if (mdio_in)
                     cnt <= (cnt == `PSLPR_SMI_PREAMBLE) ? cnt : cnt + 6'h01;
                  else
                  begin
                     // a short preamble is not a frame; wait for a full one
                     if (cnt == `PSLPR_SMI_PREAMBLE)
                        state <= SMI_HDR;
                     cnt <= 6'h00;
                  end
               end
               SMI_HDR:
               begin
                  sh <= {sh[14:0], mdio_in};
                  cnt <= cnt + 6'h01;
                  if (cnt == 6'd12)
                  begin
                     cnt <= 6'h00;
                     if (hdr[12] && hdr[9:5] == phy_addr &&
                         (hdr[11:10] == `PSLPR_SMI_OP_READ ||
                          hdr[11:10] == `PSLPR_SMI_OP_WRITE))
                     begin
                        state <= SMI_TA;
                        is_read <= (hdr[11:10] == `PSLPR_SMI_OP_READ);
                        rd_stb <= (hdr[11:10] == `PSLPR_SMI_OP_READ);
                        reg_addr <= hdr[4:0];
                     end
                     else
                        state <= SMI_IDLE;
                  end
               end
               SMI_TA:
               begin
                  cnt <= cnt + 6'h01;
                  if (cnt == 6'd1)
                  begin
                     state <= SMI_DATA;
                     cnt <= 6'h00;
                  end
               end
               SMI_DATA:
               begin
                  sh <= {sh[14:0], mdio_in};
                  cnt <= cnt + 6'h01;
                  if (cnt == 6'd15)
                  begin
                     state <= SMI_IDLE;
                     cnt <= 6'h00;
                     if (!is_read)
                     begin
                        wr_data <= {sh[14:0], mdio_in};
                        wr_stb <= 1'b1;
                     end
                  end
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // read data driven on mdc falling edges
   // ----------------------------------------
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         out_sh <= 16'h0000;
         mdio_out <= 1'b0;
         mdio_oe <= 1'b0;
      end
      else if (rise && state == SMI_TA && cnt == 6'd1 && is_read)
         out_sh <= rd_data;
      else if (fall)
      begin
         if (is_read && state == SMI_TA && cnt == 6'd1)
         begin
            mdio_out <= 1'b0;
            mdio_oe <= 1'b1;
         end
         else if (is_read && state == SMI_DATA)
         begin
            mdio_out <= out_sh[15];
            out_sh <= {out_sh[14:0], 1'b0};
            mdio_oe <= 1'b1;
         end
         else
            mdio_oe <= 1'b0;
      end
   end
endmodule // pslpr_smi
`default_nettype wire

//--- logic/pslpr_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "pslpr_params.svh"
//
// Behaviour
// - reading the cause register clears every cause bit it returned
// - summary bit 15 set means causes show in bits 14:0
// - speed and duplex change causes need negotiation enabled
// - downshift cause needs all four advertisement bits 8:5 set
// - receive error cause suppressed during carrier extension decoding
// - fixed cause bit positions, bit 6 reserved
// - aux bit 15 is negotiation complete if enabled, else link status
// - aux bit 14 is negotiation disabled or media sense with 100 fiber
// - aux bits 13:8 show crossover, pair swap and pair polarities
// - low power timeout code from bits 7 and 2; bit 6 enables mode
// - aux bit 5 duplex, bits 4:3 speed code
// - aux bits 1:0 media code
// - four 4-bit LED mode fields with defaults 8,0,2,1
// - behaviour bit 15 limits link and activity to copper
// - behaviour bit 14 splits activity into transmit and receive
// - behaviour bit 12 pulses active LEDs at 5 kHz
// - rate field picks blink rate and stretch length, default 01
// - only port 0 rate field governs all ports
// - bits 8:5 pick pulse-stretch or blink per LED
// - bits 3:0 disable merging activity or collision into LED
// - page select remaps registers 16-30, or 0-30 for GPIO page
// - page 1 bits 15:14 send remote fault, 13:12 show partner's
// - page 1 bits 9 and 8 allow fiber link-up, default one
// - sticky bits survive soft reset only when retain is enabled
// - interrupt pin follows summary flag while pin enable is set
module pslpr_regs
   import pslpr_pkg::*;
#(
   parameter int TICK_CYCLES = (`PSLPR_CLK_HZ / 1000000) * `PSLPR_LED_TICK_US,
   parameter int PULSE_ON = (`PSLPR_CLK_HZ / `PSLPR_PULSE_HZ) / 2
)
(
   input wire logic CLK,
   input wire logic NRST,
   input wire logic MDC,
   input wire logic MDIO_IN,
   output logic MDIO_OUT,
   output logic MDIO_OE,
   input wire logic [4:0] PHY_ADDR,
   input wire logic SOFT_RESET,
   input wire logic STICKY_RETAIN,
   input wire logic ANEG_EN,
   input wire logic [3:0] ADV_BITS,
   input wire logic [15:0] INT_MASK,
   input wire logic INT_PIN_EN,
   input wire logic [14:0] EVENT_IN,
   input wire logic RXER_CARRIER_EXT,
   input wire logic ANEG_COMPLETE,
   input wire logic LINK_STATUS,
   input wire logic AUTO_MEDIA_SENSE,
   input wire logic FX_MODE,
   input wire logic XOVER,
   input wire logic CD_SWAP,
   input wire logic [3:0] POL_INV,
   input wire logic FULL_DUPLEX_FLAG,
   input wire logic [1:0] SPEED,
   input wire logic [1:0] MEDIA,
   input wire logic [1:0] LINK_PARTNER_FAULT,
   input wire logic PORT_IS_ZERO,
   input wire logic [1:0] PORT0_RATE,
   input wire logic LINK_CU,
   input wire logic LINK_FI,
   input wire logic ACT_TX_CU,
   input wire logic ACT_RX_CU,
   input wire logic ACT_TX_FI,
   input wire logic ACT_RX_FI,
   input wire logic COLLISION,
   output logic MGMT_INTERRUPT_PIN,
   output logic [3:0] LED_OUT,
   output logic [1:0] BLINK_RATE,
   output logic LOWPWR_EN,
   output logic [1:0] LOWPWR_TIMEOUT,
   output logic [1:0] TX_REMOTE_FAULT,
   output logic ALLOW_1000X,
   output logic ALLOW_100FX
);
   localparam int PULSE_CYCLES = `PSLPR_CLK_HZ / `PSLPR_PULSE_HZ;
   localparam int TW = $clog2(TICK_CYCLES);
   localparam int PW = $clog2(PULSE_CYCLES);

   logic wr_stb;
   logic rd_stb;
   logic [4:0] reg_addr;
   logic [15:0] wr_data;
   logic [15:0] rd_data;
   logic [15:0] next_rd_data;
   logic [15:0] page;
   logic [15:0] led_mode;
   logic [15:0] led_beh;
   logic [15:0] aux_ctrl;
   logic [15:0] fiber_ctrl;
   logic [14:0] cause;
   logic [14:0] ev_gate;
   logic [14:0] ev_set;
   logic [14:0] cause_clr;
   logic main_sel;
   logic p1_sel;
   logic cause_rd;
   logic [15:0] aux_view;

   pslpr_smi u_smi (
      .clk(CLK),
      .nrst(NRST),
      .mdc(MDC),
      .mdio_in(MDIO_IN),
      .phy_addr(PHY_ADDR),
      .rd_data(rd_data),
      .mdio_out(MDIO_OUT),
      .mdio_oe(MDIO_OE),
      .wr_stb(wr_stb),
      .rd_stb(rd_stb),
      .reg_addr(reg_addr),
      .wr_data(wr_data)
   );

   // ----------------------------------------
   // page decode
   // ----------------------------------------
   // pages 2-4 and the gpio page hold nothing here; every register but the page register reads as zero
   assign main_sel = (page == `PSLPR_PAGE_MAIN);
   assign p1_sel = (page == `PSLPR_PAGE_EXT1);
   assign cause_rd = rd_stb && main_sel && reg_addr == `PSLPR_REG_INT_CAUSE;

   assign aux_view = {ANEG_EN ? ANEG_COMPLETE : LINK_STATUS,
                      ~ANEG_EN | (AUTO_MEDIA_SENSE & FX_MODE),
                      XOVER, CD_SWAP, POL_INV,
                      aux_ctrl[7], aux_ctrl[6],
                      FULL_DUPLEX_FLAG, SPEED,
                      aux_ctrl[2], MEDIA};

   always_comb
   begin
      next_rd_data = 16'h0000;
      if (reg_addr == `PSLPR_REG_PAGE)
         next_rd_data = page;
      else if (main_sel)
      begin
         unique case (reg_addr)
            `PSLPR_REG_INT_CAUSE: next_rd_data = {|cause, cause};
            `PSLPR_REG_AUX: next_rd_data = aux_view;
            `PSLPR_REG_LED_MODE: next_rd_data = led_mode;
            `PSLPR_REG_LED_BEH: next_rd_data = led_beh;
            default: next_rd_data = 16'h0000;
         endcase
      end
      else if (p1_sel && reg_addr == `PSLPR_REG_FIBER)
         next_rd_data = {fiber_ctrl[15:14], LINK_PARTNER_FAULT, fiber_ctrl[11:0]};
   end

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         rd_data <= 16'h0000;
      else if (rd_stb)
         rd_data <= next_rd_data;
   end

   // ----------------------------------------
   // interrupt causes
   // ----------------------------------------
   always_comb
   begin
      ev_gate = `PSLPR_CAUSE_VALID;
      ev_gate[`PSLPR_CAUSE_SPEED] = ANEG_EN;
      ev_gate[`PSLPR_CAUSE_FDX] = ANEG_EN;
      ev_gate[`PSLPR_CAUSE_DOWNSHIFT] = &ADV_BITS;
      ev_gate[`PSLPR_CAUSE_RXER] = ~RXER_CARRIER_EXT;
   end
   assign ev_set = EVENT_IN & ev_gate & INT_MASK[14:0];
   assign cause_clr = cause_rd ? cause : 15'h0000;

   // an event landing in the read cycle survives to the next read
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         cause <= 15'h0000;
      else
         cause <= (cause & ~cause_clr) | ev_set;
   end

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         MGMT_INTERRUPT_PIN <= 1'b0;
      else
         MGMT_INTERRUPT_PIN <= INT_PIN_EN & (|cause);
   end

   // ----------------------------------------
   // writable registers
   // ----------------------------------------
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         page <= `PSLPR_PAGE_MAIN;
      else if (SOFT_RESET)
         page <= `PSLPR_PAGE_MAIN;
      else if (wr_stb && reg_addr == `PSLPR_REG_PAGE)
         page <= wr_data;
   end

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         led_mode <= `PSLPR_LED_MODE_RST;
         led_beh <= `PSLPR_LED_BEH_RST;
         aux_ctrl <= `PSLPR_AUX_RST;
      end
      else if (SOFT_RESET)
      begin
         if (!STICKY_RETAIN)
         begin
            led_mode <= `PSLPR_LED_MODE_RST;
            led_beh <= `PSLPR_LED_BEH_RST;
            aux_ctrl <= `PSLPR_AUX_RST;
         end
      end
      else if (wr_stb && main_sel)
      begin
         if (reg_addr == `PSLPR_REG_LED_MODE)
            led_mode <= wr_data;
         if (reg_addr == `PSLPR_REG_LED_BEH)
            led_beh <= wr_data & `PSLPR_LED_BEH_MASK;
         if (reg_addr == `PSLPR_REG_AUX)
            aux_ctrl <= wr_data & `PSLPR_AUX_MASK;
      end
   end

   // remote fault is not sticky; the link-up permits are
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         fiber_ctrl <= `PSLPR_FIBER_RST;
      else if (SOFT_RESET)
         fiber_ctrl <= STICKY_RETAIN ? (fiber_ctrl & `PSLPR_FIBER_STICKY) : `PSLPR_FIBER_RST;
      else if (wr_stb && p1_sel && reg_addr == `PSLPR_REG_FIBER)
         fiber_ctrl <= wr_data & `PSLPR_FIBER_MASK;
   end

   assign LOWPWR_EN = aux_ctrl[6];
   assign LOWPWR_TIMEOUT = {aux_ctrl[7], aux_ctrl[2]};
   assign TX_REMOTE_FAULT = fiber_ctrl[15:14];
   assign ALLOW_1000X = fiber_ctrl[9];
   assign ALLOW_100FX = fiber_ctrl[8];

   // ----------------------------------------
   // led timing
   // ----------------------------------------
   logic [TW-1:0] tcnt;
   logic tick;
   logic [3:0] phase;
   logic [PW-1:0] pcnt;
   logic pwm_on;
   logic blink_on;
   logic link_src;
   logic act_src;
   logic fact_src;
   logic [3:0] next_led;

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         BLINK_RATE <= 2'b01;
      else
         BLINK_RATE <= PORT_IS_ZERO ? led_beh[`PSLPR_BEH_RATE_HI:`PSLPR_BEH_RATE_LO] : PORT0_RATE;
   end

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         tcnt <= '0;
         tick <= 1'b0;
         phase <= 4'h0;
      end
      else
      begin
         tick <= (tcnt == TW'(TICK_CYCLES - 1));
         tcnt <= (tcnt == TW'(TICK_CYCLES - 1)) ? '0 : tcnt + 1'b1;
         if (tick)
            phase <= phase + 4'h1;
      end
   end

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         pcnt <= '0;
      else
         pcnt <= (pcnt == PW'(PULSE_CYCLES - 1)) ? '0 : pcnt + 1'b1;
   end

   // one tick is a half period of the fastest blink
   assign blink_on = phase[2'd3 - BLINK_RATE];
   assign pwm_on = (pcnt < PW'(PULSE_ON));
   assign link_src = LINK_CU | (LINK_FI & ~led_beh[`PSLPR_BEH_CU_ONLY]);
   assign act_src = ACT_TX_CU | (ACT_RX_CU & ~led_beh[`PSLPR_BEH_TXRX])
                  | ((ACT_TX_FI | (ACT_RX_FI & ~led_beh[`PSLPR_BEH_TXRX]))
                     & ~led_beh[`PSLPR_BEH_CU_ONLY]);
   assign fact_src = ACT_RX_FI | (ACT_TX_FI & ~led_beh[`PSLPR_BEH_TXRX]);

   // ----------------------------------------
   // per led output
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_led
         logic [3:0] mode;
         logic steady;
         logic evt;
         logic shown;
         logic [4:0] str_cnt;
         assign mode = led_mode[4*gi+3:4*gi];
         // modes beyond the four basic sources are left dark here
         always_comb
         begin
            steady = 1'b0;
            evt = 1'b0;
            unique case (mode)
               4'h0:
               begin
                  steady = link_src;
                  evt = act_src & ~led_beh[gi];
               end
               4'h1: evt = act_src;
               4'h2:
               begin
                  steady = FULL_DUPLEX_FLAG;
                  evt = COLLISION & ~led_beh[gi];
               end
               4'h3: evt = fact_src;
               default:
               begin
                  steady = 1'b0;
                  evt = 1'b0;
               end
            endcase
         end
         always_ff @(posedge CLK or negedge NRST)
         begin
            if (!NRST)
               str_cnt <= 5'h00;
            else if (evt)
               str_cnt <= 5'h10 >> BLINK_RATE;
            else if (tick && str_cnt != 5'h00)
               str_cnt <= str_cnt - 5'h01;
         end
         assign shown = led_beh[`PSLPR_BEH_STRETCH_LO + gi] ? (str_cnt != 5'h00)
                                                           : (evt & blink_on);
         assign next_led[gi] = (steady ^ shown) & (~led_beh[`PSLPR_BEH_PULSE] | pwm_on);
      end
   endgenerate

   // one flop bank keeps each led bit single-driven
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
         LED_OUT <= 4'h0;
      else
         LED_OUT <= next_led;
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   cause_clear_a: assert property (@(posedge CLK) disable iff (!NRST)
      cause_rd && ev_set == 15'h0000 |=> cause == 15'h0000)
      else $error("cause not cleared by read");
   summary_view_a: assert property (@(posedge CLK) disable iff (!NRST)
      cause_rd |=> rd_data == {|$past(cause), $past(cause)})
      else $error("cause read value wrong");
   speed_gate_a: assert property (@(posedge CLK) disable iff (!NRST)
      $rose(cause[14]) || $rose(cause[12]) |-> $past(ANEG_EN))
      else $error("speed or duplex cause without negotiation");
   downshift_gate_a: assert property (@(posedge CLK) disable iff (!NRST)
      $rose(cause[2]) |-> &$past(ADV_BITS))
      else $error("downshift cause without advertisement");
   rxer_gate_a: assert property (@(posedge CLK) disable iff (!NRST)
      $rose(cause[0]) |-> !$past(RXER_CARRIER_EXT))
      else $error("rx error cause during carrier extension");
   reserved_cause_a: assert property (@(posedge CLK) disable iff (!NRST)
      cause[6] == 1'b0)
      else $error("reserved cause bit set");
   aux_complete_a: assert property (@(posedge CLK) disable iff (!NRST)
      rd_stb && main_sel && reg_addr == `PSLPR_REG_AUX
      |=> rd_data[15] == ($past(ANEG_EN) ? $past(ANEG_COMPLETE) : $past(LINK_STATUS)))
      else $error("aux bit 15 wrong");
   pin_follow_a: assert property (@(posedge CLK) disable iff (!NRST)
      ##1 MGMT_INTERRUPT_PIN == ($past(INT_PIN_EN) && (|$past(cause))))
      else $error("interrupt pin does not follow summary");
   page_route_a: assert property (@(posedge CLK) disable iff (!NRST)
      wr_stb && reg_addr == `PSLPR_REG_FIBER && !p1_sel && !SOFT_RESET
      |=> $stable(fiber_ctrl))
      else $error("fiber register written outside page 1");
   sticky_keep_a: assert property (@(posedge CLK) disable iff (!NRST)
      SOFT_RESET && STICKY_RETAIN |=> $stable(led_mode) && $stable(led_beh))
      else $error("sticky bits lost on soft reset");
   pulse_gap_a: assert property (@(posedge CLK) disable iff (!NRST)
      led_beh[12] && !pwm_on |=> LED_OUT == 4'h0)
      else $error("led lit in pulse gap");
endmodule // pslpr_regs
`default_nettype wire

//--- bench/pslpr_mgmt_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// station manager model
// ----------------------------------------
module pslpr_mgmt_model
(
   input wire logic clk,
   input wire logic mdio_out,
   input wire logic mdio_oe,
   output logic mdc,
   output logic mdio_in
);
   logic drv = 1'b1;
   logic [15:0] sr;
   // pull-up: a released line reads one
   assign mdio_in = mdio_oe ? mdio_out : drv;
   // mdc stands low between frames
   initial mdc = 1'b0;
   task automatic frame(input logic rd, input logic [4:0] ra, input logic [15:0] wd);
      logic [63:0] f;
      f = {32'hffffffff, 2'b01, rd, ~rd, 5'h03, ra, 1'b1, rd, rd ? 16'hffff : wd};
      for (int i = 63; i >= 0; i--)
      begin
         drv <= f[i];
         repeat (5) @(posedge clk);
         mdc <= 1'b1;
         repeat (5) @(posedge clk);
         sr = {sr[14:0], mdio_in};
         mdc <= 1'b0;
      end
      drv <= 1'b1;
   endtask
endmodule // pslpr_mgmt_model
`default_nettype wire

//--- bench/test_pslpr_regs.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// register slice bench
// ----------------------------------------
module test_pslpr_regs;
   logic clk = 1'b0, nrst = 1'b0, sres = 1'b0, ret = 1'b0, aneg = 1'b1, pen = 1'b0, rxe = 1'b0;
   logic anc, lnk, auto_media_sense, fx, xo, cds, full_duplex_flag, p0z, lcu, lfi, atc, arc, atf, arf, col;
   logic mdc, mdi, mdo, moe, pin, lpe, a1g, a1h;
   logic [3:0] adv = 4'hf, pol, led;
   logic [15:0] msk = 16'hffff, q, r;
   logic [15:0] pg [4] = '{16'h0002, 16'h0003, 16'h0004, 16'h0010};
   logic [14:0] ev = 15'h0000, c;
   logic [1:0] spd, med, lpf, p0r, rate, lpt, trf;
   int errors = 0, num_checks = 0, cyc = 0;
   pslpr_regs #(.TICK_CYCLES(8), .PULSE_ON(4)) i_pslpr_regs (
      .CLK(clk), .NRST(nrst), .MDC(mdc), .MDIO_IN(mdi), .MDIO_OUT(mdo), .MDIO_OE(moe),
      .PHY_ADDR(5'h03), .SOFT_RESET(sres), .STICKY_RETAIN(ret), .ANEG_EN(aneg),
      .ADV_BITS(adv), .INT_MASK(msk), .INT_PIN_EN(pen), .EVENT_IN(ev), .RXER_CARRIER_EXT(rxe),
      .ANEG_COMPLETE(anc), .LINK_STATUS(lnk), .AUTO_MEDIA_SENSE(auto_media_sense), .FX_MODE(fx), .XOVER(xo),
      .CD_SWAP(cds), .POL_INV(pol), .FULL_DUPLEX_FLAG(full_duplex_flag), .SPEED(spd), .MEDIA(med),
      .LINK_PARTNER_FAULT(lpf), .PORT_IS_ZERO(p0z), .PORT0_RATE(p0r), .LINK_CU(lcu),
      .LINK_FI(lfi), .ACT_TX_CU(atc), .ACT_RX_CU(arc), .ACT_TX_FI(atf), .ACT_RX_FI(arf),
      .COLLISION(col), .MGMT_INTERRUPT_PIN(pin), .LED_OUT(led), .BLINK_RATE(rate),
      .LOWPWR_EN(lpe), .LOWPWR_TIMEOUT(lpt), .TX_REMOTE_FAULT(trf), .ALLOW_1000X(a1g),
      .ALLOW_100FX(a1h));
   pslpr_mgmt_model i_pslpr_mgmt_model (.clk(clk), .mdio_out(mdo), .mdio_oe(moe), .mdc(mdc),
      .mdio_in(mdi));
   initial forever #50 clk = ~clk;
   // about 50k cycles of frames expected
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 90000)
      begin
         errors++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      num_checks++;
      if (g !== e)
      begin
         errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic rd(input logic [4:0] a);
      i_pslpr_mgmt_model.frame(1'b1, a, 16'h0000);
      q = i_pslpr_mgmt_model.sr;
   endtask
   task automatic wrrd(input logic [4:0] a, input logic [15:0] d);
      i_pslpr_mgmt_model.frame(1'b0, a, d);
      rd(a);
   endtask
   task automatic rnd();
      {anc, lnk, auto_media_sense, fx, xo, cds, full_duplex_flag, p0z, lcu, lfi, atc, arc, atf, arf, col, pol, spd, med,
         lpf, p0r} <= $urandom;
   endtask
   function automatic logic [15:0] eaux(input logic [15:0] w);
      return {aneg ? anc : lnk, ~aneg | (auto_media_sense & fx), xo, cds, pol, w[7:6], full_duplex_flag, spd, w[2], med};
   endfunction
   function automatic logic [14:0] ecause(input logic [14:0] e);
      logic [14:0] g;
      g = 15'h7fbf & msk[14:0];
      g[14] = g[14] & aneg;
      g[12] = g[12] & aneg;
      g[2] = g[2] & (adv == 4'hf);
      g[0] = g[0] & ~rxe;
      return e & g;
   endfunction
   initial
   begin
      r = $urandom(72);
      repeat (4) @(posedge clk);
      rnd();
      nrst <= 1'b1;
      @(posedge clk);
      rd(5'h1f);
      chk(q, 16'h0000);
      rd(5'h1d);
      chk(q, 16'h8021);
      rd(5'h1e);
      chk(q, 16'h0400);
      repeat (4)
      begin
         rnd();
         aneg <= $urandom;
         r = $urandom;
         wrrd(5'h1c, r);
         chk(q, eaux(r));
         chk({13'h0, lpe, lpt}, {13'h0, r[6], r[7], r[2]});
         wrrd(5'h1e, r);
         chk(q, r & 16'hddef);
         chk({14'h0, rate}, {14'h0, p0z ? r[11:10] : p0r});
      end
      wrrd(5'h1d, 16'h2222);
      chk(q, 16'h2222);
      wrrd(5'h1e, 16'h000f);
      chk({12'h0, led}, {12'h0, {4{full_duplex_flag}}});
      repeat (6)
      begin
         {aneg, rxe} <= $urandom;
         adv <= $urandom_range(14, 15);
         msk <= $urandom;
         rd(5'h1a);
         pen <= $urandom;
         r = $urandom;
         @(posedge clk);
         ev <= r[14:0];
         @(posedge clk);
         ev <= 15'h0000;
         c = ecause(r[14:0]);
         repeat (3) @(posedge clk);
         chk({15'h0, pin}, {15'h0, pen & (|c)});
         rd(5'h1a);
         chk(q, {|c, c});
         rd(5'h1a);
         chk(q, 16'h0000);
      end
      foreach (pg[i])
      begin
         wrrd(5'h1f, pg[i]);
         chk(q, pg[i]);
         rd(5'h1d);
         chk(q, 16'h0000);
      end
      for (int k = 0; k < 2; k++)
      begin
         r = $urandom;
         wrrd(5'h1f, 16'h0000);
         wrrd(5'h10, ~r);
         chk(q, 16'h0000);
         wrrd(5'h1d, r);
         chk(q, r);
         wrrd(5'h1f, 16'h0001);
         wrrd(5'h10, r);
         chk(q, (r & 16'hc300) | {2'b00, lpf, 12'h000});
         chk({12'h0, trf, a1g, a1h}, {12'h0, r[15:14], r[9:8]});
         ret <= k[0];
         @(posedge clk);
         sres <= 1'b1;
         @(posedge clk);
         sres <= 1'b0;
         @(posedge clk);
         chk({12'h0, trf, a1g, a1h}, {14'h0, k ? r[9:8] : 2'b11});
         rd(5'h1f);
         chk(q, 16'h0000);
         rd(5'h1d);
         chk(q, k ? r : 16'h8021);
      end
      end_of_test();
   end
endmodule // test_pslpr_regs
`default_nettype wire
